// File: hw/thermal_pkg.sv
// constants and types shared by the thermal threshold monitor
package thermal_pkg;
    // warning thresholds 80, 95, 110, 125, 140, 155 degc, bit 0 the lowest
    localparam int                THRESH_N      = 6;
    localparam int                FLAG_W        = THRESH_N + 1;
    localparam int                SD_BIT        = THRESH_N;
    localparam int                ADDR_W        = 4;
    localparam int                DATA_W        = 8;
    localparam int                DB_W          = 10;
    localparam int                SCHED_W       = 19;
    // timing
    localparam real               CLK_MHZ       = 100.0;
    localparam real               DEBOUNCE_US   = 10.0;
    localparam real               WINDOW_US     = 450.0;
    localparam real               INTERVAL_MS   = 3.0;
    localparam int                DEBOUNCE_CYC  = int'($ceil(DEBOUNCE_US * CLK_MHZ));
    localparam int                WINDOW_CYC    = int'($floor(WINDOW_US * CLK_MHZ));
    localparam int                INTERVAL_CYC  = int'($floor(INTERVAL_MS * 1000.0 * CLK_MHZ));
    // register map
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_FLAG     = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_BLOCK    = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_LIVE     = 4'h3;
    localparam int                CTRL_ON_BIT   = 0;
    localparam int                CTRL_CONT_BIT = 1;
    localparam logic              CTRL_ON_RST   = 1'h1;
    localparam logic              CTRL_CONT_RST = 1'h1;
    localparam logic [FLAG_W-1:0] BLOCK_RST     = 7'h00;
    // sensor power schedule
    typedef enum logic [3:0]
    {
        SCH_OFF  = 4'h1,
        SCH_CONT = 4'h2,
        SCH_WIN  = 4'h4,
        SCH_GAP  = 4'h8
    } sched_state_t;
endpackage

// File: hw/threshold_debounce.sv
// debounce and hysteresis for one temperature comparison
`timescale 1ns/100ps
module threshold_debounce
(
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic clear,
    input  wire logic sample,
    input  wire logic rise,
    input  wire logic hold,
    output logic      live
);
    import thermal_pkg::*;

    logic [DB_W-1:0] cnt_r;
    logic [DB_W-1:0] cnt_nxt;
    logic            live_r;
    logic            live_nxt;
    wire             want;
    wire             done;

    // set on the threshold, release only below the hysteresis level or on clear
    assign want     = live_r ? !hold : rise;
    assign done     = cnt_r == DB_W'(DEBOUNCE_CYC - 1);
    // any bounce restarts the count, both directions
    assign cnt_nxt  = (clear || !sample || !want || done) ? '0 : cnt_r + 1'b1;
    assign live_nxt = clear ? 1'b0 : (sample && want && done) ? !live_r : live_r;
    assign live     = live_r;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            cnt_r  <= '0;
            live_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            live_r <= live_nxt;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    chk_debounce_len: assert property (
        $changed(live_r) && !$past(clear) |-> $past(cnt_r) == DB_W'(DEBOUNCE_CYC - 1)
    ) else $error("sense changed before the debounce time");
endmodule

// File: hw/sample_scheduler.sv
// sensor power schedule: continuous or sampled window
`timescale 1ns/100ps
module sample_scheduler
#(
    parameter int WINDOW_CYC   = thermal_pkg::WINDOW_CYC,
    parameter int INTERVAL_CYC = thermal_pkg::INTERVAL_CYC
)
(
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic continuous,
    input  wire logic standby,
    output logic      power
);
    import thermal_pkg::*;

    sched_state_t       state_r;
    sched_state_t       state_nxt;
    logic [SCHED_W-1:0] cnt_r;
    logic [SCHED_W-1:0] cnt_nxt;
    wire                want_cont;
    wire                win_end;
    wire                gap_end;

    // standby forces sampling whatever continuous says
    assign want_cont = continuous && !standby;
    assign win_end   = cnt_r == SCHED_W'(WINDOW_CYC - 1);
    assign gap_end   = cnt_r == SCHED_W'(INTERVAL_CYC - 1);
    assign power     = state_r == SCH_CONT || state_r == SCH_WIN;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 1'b1;
        case (state_r)
            SCH_WIN:
                if (win_end)
                    state_nxt = SCH_GAP;
            SCH_GAP:
                if (gap_end)
                begin
                    state_nxt = SCH_WIN;
                    cnt_nxt   = '0;
                end
            default:
            begin
                state_nxt = SCH_WIN;
                cnt_nxt   = '0;
            end
        endcase
        if (want_cont)
            state_nxt = SCH_CONT;
        if (!enable)
            state_nxt = SCH_OFF;
        if (state_nxt == SCH_CONT || state_nxt == SCH_OFF)
            cnt_nxt = '0;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_r <= SCH_OFF;
            cnt_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    chk_sample_period: assert property (
        (state_r == SCH_WIN |-> cnt_r < SCHED_W'(WINDOW_CYC))
        and (state_r == SCH_GAP |-> cnt_r < SCHED_W'(INTERVAL_CYC))
    ) else $error("sampling window or interval overran");

    chk_standby_sampled: assert property (
        standby |=> state_r != SCH_CONT
    ) else $error("sensor stayed continuous in standby");
endmodule

// File: hw/thermal_threshold_monitor.sv
// thermal threshold monitor top: sync, thresholds, shutdown, registers, interrupt
//
// Contract
// - events use only the die-centre sensor
// - six thresholds, each flag, live, block
// - rising across threshold sets its flag
// - live clears only below hysteresis level; code also clears warning live when monitor is switched off
// - shutdown held until cooled past hysteresis
// - ten microsecond debounce, both directions
// - monitor off disables all monitoring
// - run plus continuous keeps sensor powered
// - otherwise 450 us window per 3 ms
// - standby always samples, only when enabled
// - unmasked set flag drives interrupt low
`timescale 1ns/100ps
module thermal_threshold_monitor
#(
    parameter int WINDOW_CYC   = thermal_pkg::WINDOW_CYC,
    parameter int INTERVAL_CYC = thermal_pkg::INTERVAL_CYC
)
(
    input  wire logic                                 clock,
    input  wire logic                                 reset,
    // register port
    input  wire logic [thermal_pkg::ADDR_W-1:0]       addr,
    input  wire logic [thermal_pkg::DATA_W-1:0]       wdata,
    input  wire logic                                 wr_en,
    input  wire logic                                 rd_en,
    output logic      [thermal_pkg::DATA_W-1:0]       rdata,
    // die-centre comparators, asynchronous levels
    input  wire logic [thermal_pkg::THRESH_N-1:0]     cmp_rise,
    input  wire logic [thermal_pkg::THRESH_N-1:0]     cmp_hold,
    input  wire logic                                 sd_rise,
    input  wire logic                                 sd_hold,
    // chip power state, same clock
    input  wire logic                                 standby,
    // outputs
    output logic                                      sensor_power,
    output logic                                      thermal_shutdown,
    output logic                                      irq_out_n
);
    import thermal_pkg::*;

    // synchronisers
    logic [THRESH_N-1:0] rise_meta_r;
    logic [THRESH_N-1:0] rise_s_r;
    logic [THRESH_N-1:0] hold_meta_r;
    logic [THRESH_N-1:0] hold_s_r;
    logic [1:0]          sd_meta_r;
    logic [1:0]          sd_s_r;

    // control and status
    logic                temp_monitor_on_r;
    logic                temp_monitor_continuous_r;
    logic [FLAG_W-1:0]   thermal_threshold_block_r;
    logic [FLAG_W-1:0]   thermal_threshold_flag_r;
    logic [FLAG_W-1:0]   thermal_threshold_flag_nxt;
    logic [FLAG_W-1:0]   live_prev_r;
    logic [DATA_W-1:0]   rdata_r;
    logic [DATA_W-1:0]   rdata_nxt;
    logic                irq_n_r;
    logic                irq_n_nxt;

    // sense and schedule
    logic [THRESH_N-1:0] thermal_threshold_live;
    logic                sd_live;
    logic                power;
    wire  [FLAG_W-1:0]   live_all;
    wire  [FLAG_W-1:0]   live_event;
    wire                 thr_clear;

    // register decode
    wire                 sel_ctrl;
    wire                 sel_flag;
    wire                 sel_block;
    wire                 sel_live;
    wire                 wr_ctrl;
    wire                 wr_flag;
    wire                 wr_block;
    wire  [FLAG_W-1:0]   w1c_mask;
    wire  [FLAG_W-1:0]   block_nxt;
    wire  [DATA_W-1:0]   ctrl_view;
    wire  [DATA_W-1:0]   read_val;

    // only the centre-of-die comparators reach this block
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rise_meta_r <= '0;
            rise_s_r    <= '0;
            hold_meta_r <= '0;
            hold_s_r    <= '0;
            sd_meta_r   <= '0;
            sd_s_r      <= '0;
        end
        else
        begin
            rise_meta_r <= cmp_rise;
            rise_s_r    <= rise_meta_r;
            hold_meta_r <= cmp_hold;
            hold_s_r    <= hold_meta_r;
            sd_meta_r   <= {sd_hold, sd_rise};
            sd_s_r      <= sd_meta_r;
        end
    end

    // power schedule of the sensor
    sample_scheduler
    #(
        .WINDOW_CYC   (WINDOW_CYC),
        .INTERVAL_CYC (INTERVAL_CYC)
    )
    u_sched
    (
        .clock      (clock),
        .reset      (reset),
        .enable     (temp_monitor_on_r),
        .continuous (temp_monitor_continuous_r),
        .standby    (standby),
        .power      (power)
    );

    // warning senses drop when the monitor is switched off
    assign thr_clear = !temp_monitor_on_r;

    // one debounced sense per warning threshold
    genvar gi;
    generate
        for (gi = 0; gi < THRESH_N; gi++)
        begin : g_thr
            threshold_debounce u_deb
            (
                .clock  (clock),
                .reset  (reset),
                .clear  (thr_clear),
                .sample (power),
                .rise   (rise_s_r[gi]),
                .hold   (hold_s_r[gi]),
                .live   (thermal_threshold_live[gi])
            );
        end
    endgenerate

    // shutdown sense survives a monitor disable, so restart stays blocked
    threshold_debounce u_sd
    (
        .clock  (clock),
        .reset  (reset),
        .clear  (1'b0),
        .sample (power),
        .rise   (sd_s_r[0]),
        .hold   (sd_s_r[1]),
        .live   (sd_live)
    );

    // events: rising edge of each sense
    assign live_all   = {sd_live, thermal_threshold_live};
    assign live_event = live_all & ~live_prev_r;

    // register decode
    assign sel_ctrl  = addr == ADDR_CTRL;
    assign sel_flag  = addr == ADDR_FLAG;
    assign sel_block = addr == ADDR_BLOCK;
    assign sel_live  = addr == ADDR_LIVE;
    assign wr_ctrl   = wr_en && sel_ctrl;
    assign wr_flag   = wr_en && sel_flag;
    assign wr_block  = wr_en && sel_block;

    // write one to clear; a new event wins over the clear
    assign w1c_mask = wr_flag ? wdata[FLAG_W-1:0] : '0;
    assign thermal_threshold_flag_nxt = (thermal_threshold_flag_r & ~w1c_mask)
                                      | live_event;
    assign block_nxt = wr_block ? wdata[FLAG_W-1:0] : thermal_threshold_block_r;

    // interrupt low while any unblocked flag stands
    assign irq_n_nxt = ~|(thermal_threshold_flag_nxt & ~block_nxt);

    // read mux, unmapped reads zero
    assign ctrl_view = DATA_W'({temp_monitor_continuous_r, temp_monitor_on_r});
    assign read_val  = sel_ctrl  ? ctrl_view
                     : sel_flag  ? DATA_W'(thermal_threshold_flag_r)
                     : sel_block ? DATA_W'(thermal_threshold_block_r)
                     : sel_live  ? DATA_W'(live_all)
                     : '0;
    assign rdata_nxt = rd_en ? read_val : '0;

    // control registers
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            temp_monitor_on_r         <= CTRL_ON_RST;
            temp_monitor_continuous_r <= CTRL_CONT_RST;
        end
        else if (wr_ctrl)
        begin
            temp_monitor_on_r         <= wdata[CTRL_ON_BIT];
            temp_monitor_continuous_r <= wdata[CTRL_CONT_BIT];
        end
    end

    // status, mask, read data, interrupt
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            thermal_threshold_flag_r  <= '0;
            thermal_threshold_block_r <= BLOCK_RST;
            live_prev_r               <= '0;
            rdata_r                   <= '0;
            irq_n_r                   <= 1'b1;
        end
        else
        begin
            thermal_threshold_flag_r  <= thermal_threshold_flag_nxt;
            thermal_threshold_block_r <= block_nxt;
            live_prev_r               <= live_all;
            rdata_r                   <= rdata_nxt;
            irq_n_r                   <= irq_n_nxt;
        end
    end

    // outputs
    assign rdata            = rdata_r;
    assign irq_out_n        = irq_n_r;
    assign sensor_power     = power;
    assign thermal_shutdown = sd_live;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    chk_flag_on_rise: assert property (
        live_event != '0 |=> (thermal_threshold_flag_r & $past(live_event))
                             == $past(live_event)
    ) else $error("sense rose without setting its flag");

    chk_flag_sticky: assert property (
        !wr_flag |=> (thermal_threshold_flag_r & $past(thermal_threshold_flag_r))
                     == $past(thermal_threshold_flag_r)
    ) else $error("flag dropped without a host clear");

    chk_flag_cleared: assert property (
        wr_flag && live_event == '0
        |=> (thermal_threshold_flag_r & $past(w1c_mask)) == '0
    ) else $error("write of one did not clear the flag");

    chk_irq_masked: assert property (
        ##1 irq_out_n == !(|(thermal_threshold_flag_r & ~thermal_threshold_block_r))
    ) else $error("interrupt does not match unblocked flags");

    chk_monitor_off: assert property (
        !temp_monitor_on_r [*3] |-> thermal_threshold_live == '0 && !sensor_power
    ) else $error("monitoring active while disabled");

    chk_continuous_run: assert property (
        (temp_monitor_on_r && temp_monitor_continuous_r && !standby) [*2]
        |-> sensor_power
    ) else $error("sensor not powered in continuous run");

    chk_sense_release: assert property (
        ((live_prev_r[THRESH_N-1:0] & ~thermal_threshold_live)
         & $past(hold_s_r) & {THRESH_N{$past(temp_monitor_on_r)}}) == '0
    ) else $error("sense released above the hysteresis level");

    chk_shutdown_hold: assert property (
        $fell(thermal_shutdown) |-> !$past(sd_s_r[1])
    ) else $error("shutdown released before cooling past hysteresis");

    chk_shutdown_entry: assert property (
        $rose(thermal_shutdown) |-> $past(sd_s_r[0]) && $past(sensor_power)
    ) else $error("shutdown entered without the comparator");

    chk_read_timing: assert property (
        !$past(rd_en) |-> rdata == '0
    ) else $error("read data outside its cycle");

    chk_read_data: assert property (
        $past(rd_en) |-> rdata == $past(read_val)
    ) else $error("read data not taken from the addressed register");

    chk_read_upper: assert property (
        rdata[DATA_W-1:FLAG_W] == '0
    ) else $error("unused read bits not zero");

    chk_ctrl_write: assert property (
        wr_ctrl |=> temp_monitor_on_r == $past(wdata[CTRL_ON_BIT])
                    && temp_monitor_continuous_r == $past(wdata[CTRL_CONT_BIT])
    ) else $error("control write not taken");

    chk_ctrl_hold: assert property (
        !wr_ctrl |=> $stable({temp_monitor_on_r, temp_monitor_continuous_r})
    ) else $error("control changed without a write");

    chk_block_write: assert property (
        wr_block |=> thermal_threshold_block_r == $past(wdata[FLAG_W-1:0])
    ) else $error("block write not taken");

    chk_block_hold: assert property (
        !wr_block |=> $stable(thermal_threshold_block_r)
    ) else $error("block changed without a write");

    chk_irq_on_event: assert property (
        (live_event & ~block_nxt) != '0 |=> !irq_out_n
    ) else $error("unblocked event did not raise the interrupt");

    chk_irq_release: assert property (
        (thermal_threshold_flag_nxt & ~block_nxt) == '0 |=> irq_out_n
    ) else $error("interrupt held with no unblocked flag");

    chk_flag_only_event: assert property (
        ((thermal_threshold_flag_r & ~$past(thermal_threshold_flag_r))
         & ~$past(live_event)) == '0
    ) else $error("flag set without a rising sense");

    chk_sense_needs_rise: assert property (
        ((thermal_threshold_live & ~live_prev_r[THRESH_N-1:0]) & ~$past(rise_s_r)) == '0
    ) else $error("sense set without the rising comparator");

    chk_sync_chain: assert property (
        rise_s_r == $past(rise_meta_r) && hold_s_r == $past(hold_meta_r)
        && sd_s_r == $past(sd_meta_r)
    ) else $error("comparator skipped a synchroniser stage");

    chk_live_powered: assert property (
        $changed(thermal_threshold_live) && $past(temp_monitor_on_r) |-> $past(sensor_power)
    ) else $error("sense changed while the sensor was unpowered");

    chk_shutdown_powered: assert property (
        $changed(thermal_shutdown) |-> $past(sensor_power)
    ) else $error("shutdown changed while the sensor was unpowered");

    chk_shutdown_kept: assert property (
        !temp_monitor_on_r && !sensor_power |=> $stable(thermal_shutdown)
    ) else $error("shutdown state lost while monitoring was off");

    chk_shutdown_flag: assert property (
        $rose(thermal_shutdown) |=> thermal_threshold_flag_r[SD_BIT]
    ) else $error("shutdown entry did not set its flag");

    chk_off_unpowered: assert property (
        !temp_monitor_on_r |=> !sensor_power
    ) else $error("sensor powered after the monitor was switched off");

    chk_off_cleared: assert property (
        !temp_monitor_on_r |=> thermal_threshold_live == '0
    ) else $error("warning senses kept after the monitor was switched off");
endmodule

// File: verification/host_model.sv
// host model: register bus master that also clears latched flags
`timescale 1ns/100ps
module host_model
(
    input  wire logic                      clock,
    output logic [thermal_pkg::ADDR_W-1:0] addr,
    output logic [thermal_pkg::DATA_W-1:0] wdata,
    output logic                           wr_en,
    output logic                           rd_en
);
    import thermal_pkg::*;
    initial
    begin
        addr = '0;
        wdata = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    // one strobe cycle, then bus released to inverted values
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= ~w;
        @(posedge clock);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic ack_irq(input logic [DATA_W-1:0] bits);
        access(1'b1, ADDR_FLAG, bits);
    endtask
endmodule

// File: verification/thermal_threshold_monitor_bench.sv
// self-checking bench for the thermal threshold monitor
`timescale 1ns/100ps
module thermal_threshold_monitor_bench;
    import thermal_pkg::*;
    localparam int WIN_CYC = 1100;
    localparam int INT_CYC = 3000;
    logic              clock = 1'b0;
    logic              reset = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rdata;
    logic [5:0]        cmp_rise = '0;
    logic [5:0]        cmp_hold = '0;
    logic              sd_rise = 1'b0;
    logic              sd_hold = 1'b0;
    logic              standby = 1'b0;
    logic              sensor_power;
    logic              thermal_shutdown;
    logic              irq_out_n;
    logic              rd_seen = 1'b0;
    logic [DATA_W-1:0] exp_q[$];
    logic [31:0]       rnd = 32'h000123DE;
    logic [5:0]        pat;
    int                n_errors = 0;
    int                n_tests = 0;
    int                cnt;
    int                wait_n;
    logic [7:0]        ctl_tab [4] = '{8'h03, 8'h01, 8'h03, 8'h00};
    logic              sby_tab [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    int                on_tab  [4] = '{6000, 2 * WIN_CYC, 2 * WIN_CYC, 0};

    always #5 clock = ~clock;

    thermal_threshold_monitor #(.WINDOW_CYC(WIN_CYC), .INTERVAL_CYC(INT_CYC)) i_thermal_threshold_monitor
    (
        .clock            (clock),
        .reset            (reset),
        .addr             (addr),
        .wdata            (wdata),
        .wr_en            (wr_en),
        .rd_en            (rd_en),
        .rdata            (rdata),
        .cmp_rise         (cmp_rise),
        .cmp_hold         (cmp_hold),
        .sd_rise          (sd_rise),
        .sd_hold          (sd_hold),
        .standby          (standby),
        .sensor_power     (sensor_power),
        .thermal_shutdown (thermal_shutdown),
        .irq_out_n        (irq_out_n)
    );

    host_model i_host_model
    (
        .clock (clock),
        .addr  (addr),
        .wdata (wdata),
        .wr_en (wr_en),
        .rd_en (rd_en)
    );

    // xorshift source, seed 74718
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check({24'h000000, got}, {24'h000000, exp});
    endtask

    // outputs as {irq_out_n, thermal_shutdown, sensor_power}
    task automatic cmp_out(input logic [2:0] exp);
        @(negedge clock);
        check({29'h0000000, irq_out_n, thermal_shutdown, sensor_power}, {29'h0000000, exp});
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        exp_q.push_back(e);
        i_host_model.access(1'b0, a, 8'h00);
    endtask

    task automatic drive(input logic [5:0] r, input logic [5:0] h, input logic sr, input logic sh);
        @(posedge clock);
        cmp_rise <= r;
        cmp_hold <= h;
        sd_rise <= sr;
        sd_hold <= sh;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clock)
    begin
        if (rd_seen)
            cmp_reg(rdata, exp_q.pop_front());
        rd_seen <= rd_en;
    end

    initial
    begin
        tick(4);
        reset <= 1'b0;
        tick(2);
        cmp_out(3'b101);
        rd(ADDR_CTRL, 8'h03);
        rd(ADDR_FLAG, 8'h00);
        rd(ADDR_BLOCK, 8'h00);
        rd(ADDR_LIVE, 8'h00);
        rd(4'hF, 8'h00);
        i_host_model.access(1'b1, ADDR_LIVE, 8'hFF);
        i_host_model.access(1'b1, 4'hF, 8'h00);
        rd(ADDR_LIVE, 8'h00);
        rd(ADDR_CTRL, 8'h03);
        // short burst then restart of the debounce count
        drive(6'h01, 6'h01, 1'b0, 1'b0);
        tick(500);
        drive(6'h00, 6'h00, 1'b0, 1'b0);
        tick(3);
        drive(6'h01, 6'h01, 1'b0, 1'b0);
        tick(990);
        cmp_out(3'b101);
        tick(20);
        cmp_out(3'b001);
        rd(ADDR_LIVE, 8'h01);
        rd(ADDR_FLAG, 8'h01);
        i_host_model.access(1'b1, ADDR_BLOCK, 8'h01);
        cmp_out(3'b101);
        i_host_model.access(1'b1, ADDR_BLOCK, 8'h00);
        cmp_out(3'b001);
        // falling edge held by the hysteresis comparator
        drive(6'h00, 6'h01, 1'b0, 1'b0);
        tick(1100);
        rd(ADDR_LIVE, 8'h01);
        drive(6'h00, 6'h00, 1'b0, 1'b0);
        tick(1010);
        rd(ADDR_LIVE, 8'h00);
        cmp_out(3'b001);
        i_host_model.ack_irq(8'h01);
        cmp_out(3'b101);
        rd(ADDR_FLAG, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            pat = (k == 0) ? 6'h3F : 6'(xs());
            drive(pat, pat, 1'b0, 1'b0);
            tick(1010);
            rd(ADDR_LIVE, {2'b00, pat});
            rd(ADDR_FLAG, {2'b00, pat});
            drive(6'h00, 6'h00, 1'b0, 1'b0);
            tick(1010);
            rd(ADDR_LIVE, 8'h00);
            i_host_model.ack_irq(8'h7F);
            rd(ADDR_FLAG, 8'h00);
        end
        drive(6'h00, 6'h00, 1'b1, 1'b1);
        tick(1010);
        cmp_out(3'b011);
        rd(ADDR_LIVE, 8'h40);
        drive(6'h00, 6'h00, 1'b0, 1'b1);
        tick(1100);
        cmp_out(3'b011);
        drive(6'h00, 6'h00, 1'b0, 1'b0);
        tick(1010);
        cmp_out(3'b001);
        i_host_model.ack_irq(8'h40);
        cmp_out(3'b101);
        i_host_model.access(1'b1, ADDR_CTRL, 8'h00);
        tick(2);
        cmp_out(3'b100);
        drive(6'h3F, 6'h3F, 1'b0, 1'b0);
        tick(1100);
        rd(ADDR_LIVE, 8'h00);
        rd(ADDR_FLAG, 8'h00);
        drive(6'h00, 6'h00, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            i_host_model.access(1'b1, ADDR_CTRL, 8'h00);
            tick(3);
            standby <= sby_tab[k];
            i_host_model.access(1'b1, ADDR_CTRL, ctl_tab[k]);
            wait_n = 0;
            while (sensor_power !== 1'b1 && wait_n < 10)
            begin
                @(negedge clock);
                wait_n++;
            end
            cnt = 0;
            repeat (6000)
            begin
                cnt += (sensor_power === 1'b1) ? 1 : 0;
                @(negedge clock);
            end
            check(cnt, on_tab[k]);
        end
        end_sim();
    end

    initial
    begin
        #1000000;
        n_errors++;
        end_sim();
    end
endmodule
